// ### hdl/psm_pkg.sv
// Shared constants and types for the power state manager.
// Assumes a single core clock; all users import the whole package.
package psm_pkg;

  // Visible power state codes
  typedef enum logic [2:0] {
    MODE_RUN   = 3'h0,
    MODE_SLOW  = 3'h1,
    MODE_IDLE  = 3'h2,
    MODE_SLEEP = 3'h3,
    MODE_DEEP  = 3'h4
  } psm_mode_t;

  // Sequencer states, one-hot
  typedef enum logic [8:0] {
    ST_RUN      = 9'h001,
    ST_SLOW     = 9'h002,
    ST_BUS_REQ  = 9'h004,
    ST_IDLE     = 9'h008,
    ST_SR_ENTER = 9'h010,
    ST_SLEEP    = 9'h020,
    ST_DEEP     = 9'h040,
    ST_WAKE_CLK = 9'h080,
    ST_WAKE_SR  = 9'h100
  } psm_state_t;

  // Wake source positions inside the synchroniser
  localparam int WAKE_USER = 0;
  localparam int WAKE_RTC = 1;
  localparam int WAKE_RST = 2;
  localparam int WAKE_RING = 3;
  localparam int WAKE_NUM = 4;

  // Synchroniser reset values (inactive levels after polarity fix)
  localparam logic [3:0] WAKE_SYNC_RST = 4'h0;

  // Default peripheral count
  localparam int PERIPH_NUM = 8;

endpackage

// ### hdl/psm_wake_if.sv
// Carrier for synchronised wake sources between the synchroniser and the sequencer.
// Assumes both ends run on core_clk.
interface psm_wake_if;
  logic user_wake;
  logic rtc_alarm;
  logic reset_req;
  logic ring;
  logic any_wake;

  modport src (output user_wake, output rtc_alarm, output reset_req, output ring,
               output any_wake);
  modport dst (input user_wake, input rtc_alarm, input reset_req, input ring,
               input any_wake);
endinterface

// ### hdl/psm_wake_sync.sv
// Two-stage synchroniser for the asynchronous wake pins.
// Assumes pins are static levels from outside the core clock domain.
module psm_wake_sync
  import psm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Raw wake pins
  input wire logic user_wake_n,
  input wire logic rtc_alarm,
  input wire logic reset_req,
  input wire logic ring_n,
  // Synchronised side
  psm_wake_if.src wk
);

  logic [WAKE_NUM-1:0] raw;
  logic [WAKE_NUM-1:0] meta;
  logic [WAKE_NUM-1:0] sync;

  // Fold pin polarity so every bit is active high
  assign raw = {~ring_n, reset_req, rtc_alarm, ~user_wake_n};

  // First stage is read only by the second stage
  generate
    for (genvar i = 0; i < WAKE_NUM; i++)
    begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta[i] <= WAKE_SYNC_RST[i];
          sync[i] <= WAKE_SYNC_RST[i];
        end
        else if (clk_en)
        begin
          meta[i] <= raw[i];
          sync[i] <= meta[i];
        end
      end
    end
  endgenerate

  assign wk.user_wake = sync[WAKE_USER];
  assign wk.rtc_alarm = sync[WAKE_RTC];
  assign wk.reset_req = sync[WAKE_RST];
  assign wk.ring = sync[WAKE_RING];
  // All four sources reach the sequencer directly
  assign wk.any_wake = |sync;

endmodule

// ### hdl/psm_top.sv
// Power state manager: sequences run, slow, idle, sleep and deep sleep.
// Assumes bus arbiter, SDRAM controller and PLL lock share core_clk; wake pins are async.
// Deep sleep is modelled on the same clock: the wake path must be fed the slow clock there.
module psm_top
  import psm_pkg::*;
#(parameter int NPER = PERIPH_NUM)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Software request
  input wire logic sw_req,
  input wire logic [2:0] sw_mode,
  // Processor and DMA
  input wire logic cpu_irq,
  input wire logic dma_bus_req,
  // Bus arbiter
  input wire logic bus_grant,
  output logic bus_req,
  // SDRAM controller and clock source
  input wire logic sdram_sr_ack,
  input wire logic clocks_stable,
  // Wake pins
  input wire logic user_wake_n,
  input wire logic rtc_alarm,
  input wire logic reset_req,
  input wire logic ring_n,
  // Peripheral controls
  input wire logic [NPER-1:0] periph_clk_off,
  input wire logic [NPER-1:0] periph_pwr_off,
  output logic [NPER-1:0] periph_clk_en,
  output logic [NPER-1:0] periph_pwr_en,
  // Power state outputs
  output logic [2:0] state_code,
  output logic core_half_rate,
  output logic cpu_halt,
  output logic cpu_resume,
  output logic sdram_sr_req,
  output logic clk_gate_off,
  output logic osc_off,
  output logic pll_off,
  output logic power_down,
  output logic ring_irq
);

  psm_wake_if wk ();
  psm_state_t state, next_state;
  logic slow_ret, deep_pend, idle_exit, asleep_next;

  psm_wake_sync u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .user_wake_n(user_wake_n),
    .rtc_alarm(rtc_alarm),
    .reset_req(reset_req),
    .ring_n(ring_n),
    .wk(wk)
  );

  // Interrupt or DMA wins over a sleep request arriving in ST_IDLE, not once in ST_SR_ENTER
  assign idle_exit = cpu_irq | dma_bus_req;
  // Next-state decode
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN, ST_SLOW:
      begin
        if (sw_req && sw_mode == MODE_SLOW)
          next_state = ST_SLOW;
        else if (sw_req && sw_mode == MODE_RUN)
          next_state = ST_RUN;
        else if (sw_req && sw_mode == MODE_IDLE)
          next_state = ST_BUS_REQ;
      end
      ST_BUS_REQ:
        if (bus_grant)
          next_state = ST_IDLE;
      ST_IDLE:
      begin
        if (idle_exit)
          next_state = slow_ret ? ST_SLOW : ST_RUN;
        else if (sw_req && (sw_mode == MODE_SLEEP || sw_mode == MODE_DEEP))
          next_state = ST_SR_ENTER;
      end
      ST_SR_ENTER:
        if (sdram_sr_ack)
          next_state = deep_pend ? ST_DEEP : ST_SLEEP;
      ST_SLEEP:
      begin
        if (wk.any_wake)
          next_state = ST_WAKE_CLK;
        else if (sw_req && sw_mode == MODE_DEEP)
          next_state = ST_DEEP;
      end
      ST_DEEP:
        if (wk.any_wake)
          next_state = ST_WAKE_CLK;
      ST_WAKE_CLK:
        if (clocks_stable)
          next_state = ST_WAKE_SR;
      ST_WAKE_SR:
        if (!sdram_sr_ack)
          next_state = slow_ret ? ST_SLOW : ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_RUN;
    else if (clk_en)
      state <= next_state;
  end

  // Remember where to return and whether deep sleep was asked for
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slow_ret <= 1'b0;
      deep_pend <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state == ST_RUN || state == ST_SLOW)
        slow_ret <= (state == ST_SLOW);
      if (state == ST_IDLE && sw_req)
        deep_pend <= (sw_mode == MODE_DEEP);
    end
  end

  assign asleep_next = (next_state == ST_SLEEP) || (next_state == ST_DEEP) ||
                       (next_state == ST_WAKE_CLK);

  // Outputs decoded from the next state so they line up with the state register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_code <= MODE_RUN;
      core_half_rate <= 1'b0;
      bus_req <= 1'b0;
      cpu_halt <= 1'b0;
      sdram_sr_req <= 1'b0;
      clk_gate_off <= 1'b0;
      osc_off <= 1'b0;
      pll_off <= 1'b0;
      power_down <= 1'b0;
    end
    else if (clk_en)
    begin
      case (next_state)
        ST_RUN: state_code <= MODE_RUN;
        ST_SLOW: state_code <= MODE_SLOW;
        ST_BUS_REQ, ST_IDLE, ST_SR_ENTER: state_code <= MODE_IDLE;
        ST_DEEP: state_code <= MODE_DEEP;
        default: state_code <= MODE_SLEEP;
      endcase
      core_half_rate <= (next_state == ST_SLOW);
      bus_req <= (next_state != ST_RUN) && (next_state != ST_SLOW);
      cpu_halt <= (next_state != ST_RUN) && (next_state != ST_SLOW) &&
                  (next_state != ST_BUS_REQ);
      sdram_sr_req <= (next_state == ST_SR_ENTER) || asleep_next || (next_state == ST_WAKE_SR);
      clk_gate_off <= asleep_next;
      osc_off <= (next_state == ST_DEEP);
      pll_off <= (next_state == ST_DEEP);
      power_down <= (next_state == ST_DEEP);
    end
  end

  // Resume pulse and ring interrupt routing
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_resume <= 1'b0;
      ring_irq <= 1'b0;
    end
    else if (clk_en)
    begin
      cpu_resume <= (state == ST_IDLE) && idle_exit;
      ring_irq <= wk.ring && !asleep_next;
    end
  end

  // Per-peripheral gating; global gating overrides the individual enables
  generate
    for (genvar i = 0; i < NPER; i++)
    begin : g_per
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          periph_clk_en[i] <= 1'b1;
          periph_pwr_en[i] <= 1'b1;
        end
        else if (clk_en)
        begin
          periph_clk_en[i] <= !periph_clk_off[i] && !asleep_next;
          periph_pwr_en[i] <= !periph_pwr_off[i] && (next_state != ST_DEEP);
        end
      end
    end
  endgenerate

  // Checks share the one core clock and sleep through reset
  default clocking cb_core @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_run_free;
    state_code == MODE_RUN |-> !clk_gate_off && !sdram_sr_req && !core_half_rate;
  endproperty
  a_run_free: assert property (p_run_free) else $error("run with clocks gated");
  property p_slow_half;
    core_half_rate |-> state_code == MODE_SLOW && !bus_req;
  endproperty
  a_slow_half: assert property (p_slow_half) else $error("half rate outside slow");
  property p_idle_hold;
    (state == ST_IDLE && clk_en && !idle_exit && !sw_req) |=>
      state_code == MODE_IDLE && bus_req && cpu_halt;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle left without cause");
  property p_sleep_from_idle;
    $rose(sdram_sr_req) |-> $past(bus_req) && $past(state_code) == MODE_IDLE;
  endproperty
  a_sleep_from_idle: assert property (p_sleep_from_idle) else $error("sleep not from idle");
  property p_gate_after_ack;
    $rose(clk_gate_off) |-> $past(sdram_sr_ack) && sdram_sr_req;
  endproperty
  a_gate_after_ack: assert property (p_gate_after_ack) else $error("gated before ack");
  property p_deep_off;
    osc_off |-> pll_off && power_down && clk_gate_off && sdram_sr_req && state_code == MODE_DEEP;
  endproperty
  a_deep_off: assert property (p_deep_off) else $error("deep sleep incomplete");
  property p_deep_pwr;
    power_down |-> periph_pwr_en == '0 && sdram_sr_req;
  endproperty
  a_deep_pwr: assert property (p_deep_pwr) else $error("peripheral powered in deep");
  property p_wake;
    (state == ST_DEEP && clk_en && wk.any_wake) |=> !osc_off && clk_gate_off;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not taken");
  property p_sr_exit_order;
    $fell(sdram_sr_req) |-> !clk_gate_off && !osc_off && $past(clocks_stable, 2);
  endproperty
  a_sr_exit_order: assert property (p_sr_exit_order) else $error("memory woke first");
  property p_resume;
    (state == ST_IDLE && clk_en && cpu_irq) |=> cpu_resume && !cpu_halt;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume on interrupt");
  property p_ring_route;
    (clk_en && wk.ring && state == ST_RUN && next_state == ST_RUN) |=> ring_irq;
  endproperty
  a_ring_route: assert property (p_ring_route) else $error("ring not routed");

  // Main scenarios reached
  c_deep: cover property ($rose(osc_off));
  c_wake: cover property ($fell(sdram_sr_req) ##1 state_code == MODE_RUN);
  c_idle_irq: cover property ($rose(cpu_resume));
  c_slow: cover property ($rose(core_half_rate));

endmodule

// ### bench/psm_partner.sv
// Far-side model: bus arbiter, SDRAM controller and clock source.
// Assumes it shares core_clk with the power manager; DLY sets how slowly it answers.
module psm_lag #(parameter int DLY = 2) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Wanted and shown level
  input wire logic d,
  output logic q
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // Follow d only once it has differed for DLY edges
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt <= 0;
      q <= 1'b0;
    end
    else if (d == q)
      cnt <= 0;
    else if (cnt >= DLY)
    begin
      q <= d;
      cnt <= 0;
    end
    else
      cnt <= cnt + 1;
endmodule

module psm_partner #(parameter int DLY = 2) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // From the power manager
  input wire logic bus_req,
  input wire logic sdram_sr_req,
  input wire logic clk_gate_off,
  input wire logic osc_off,
  // Answers
  output logic bus_grant,
  output logic sdram_sr_ack,
  output logic clocks_stable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic seen;
  // Ack drops only after clocks return from a stop
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      seen <= 1'b0;
    else if (!sdram_sr_req)
      seen <= 1'b0;
    else if (sdram_sr_ack && clk_gate_off)
      seen <= 1'b1;
  // Arbiter grants late, never early
  psm_lag #(.DLY(DLY)) u_psm_lag_bus (.core_clk(core_clk), .rst_n(rst_n),
    .d(bus_req), .q(bus_grant));
  psm_lag #(.DLY(DLY)) u_psm_lag_sr (.core_clk(core_clk), .rst_n(rst_n),
    .d(sdram_sr_req && !(seen && !clk_gate_off)), .q(sdram_sr_ack));
  psm_lag #(.DLY(DLY)) u_psm_lag_clk (.core_clk(core_clk), .rst_n(rst_n),
    .d(!osc_off), .q(clocks_stable));
endmodule

// ### bench/power_state_manager_tb.sv
// Self-checking bench for the power state manager.
// Assumes psm_pkg and the design files are compiled first.
module power_state_manager_tb
  import psm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst_n = 0, clk_en = 1, sw_req = 0, cpu_irq = 0, dma_bus_req = 0;
  logic user_wake_n = 1, rtc_alarm = 0, reset_req = 0, ring_n = 1;
  logic [2:0] sw_mode = 0, state_code, last_code = 0;
  logic [7:0] periph_clk_off = 0, periph_pwr_off = 0, periph_clk_en, periph_pwr_en;
  logic bus_grant, bus_req, sdram_sr_ack, sdram_sr_req, clocks_stable, core_half_rate;
  logic cpu_halt, cpu_resume, clk_gate_off, osc_off, pll_off, power_down, ring_irq;
  logic [31:0] seed = 32'h14;
  logic [2:0] exp_q[$];
  int error_cnt = 0, compares = 0;

  always #5 core_clk = ~core_clk;

  psm_top #(.NPER(8)) u_psm_top (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .sw_req(sw_req), .sw_mode(sw_mode), .cpu_irq(cpu_irq), .dma_bus_req(dma_bus_req),
    .bus_grant(bus_grant), .bus_req(bus_req), .sdram_sr_ack(sdram_sr_ack),
    .clocks_stable(clocks_stable), .user_wake_n(user_wake_n), .rtc_alarm(rtc_alarm),
    .reset_req(reset_req), .ring_n(ring_n), .periph_clk_off(periph_clk_off),
    .periph_pwr_off(periph_pwr_off), .periph_clk_en(periph_clk_en),
    .periph_pwr_en(periph_pwr_en), .state_code(state_code),
    .core_half_rate(core_half_rate), .cpu_halt(cpu_halt), .cpu_resume(cpu_resume),
    .sdram_sr_req(sdram_sr_req), .clk_gate_off(clk_gate_off), .osc_off(osc_off),
    .pll_off(pll_off), .power_down(power_down), .ring_irq(ring_irq));
  psm_partner #(.DLY(3)) u_psm_partner (.core_clk(core_clk), .rst_n(rst_n),
    .bus_req(bus_req), .sdram_sr_req(sdram_sr_req), .clk_gate_off(clk_gate_off),
    .osc_off(osc_off), .bus_grant(bus_grant), .sdram_sr_ack(sdram_sr_ack),
    .clocks_stable(clocks_stable));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compares %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One-cycle request strobe, outputs settled on return
  task automatic req(input logic [2:0] m);
    @(posedge core_clk);
    sw_req <= 1'b1;
    sw_mode <= m;
    @(posedge core_clk);
    sw_req <= 1'b0;
    #1;
  endtask

  // Bounded wait; a miss ends the run
  task automatic wait_until(input int sel, input logic [2:0] v);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 300 && !hit; n++)
    begin
      @(posedge core_clk);
      #1;
      case (sel)
        0: hit = (state_code === v);
        1: hit = (clk_gate_off === v[0]);
        2: hit = (bus_grant === v[0]);
        default: hit = (ring_irq === v[0]);
      endcase
    end
    if (!hit)
    begin
      error_cnt++;
      conclude();
    end
  endtask

  task automatic enter_idle();
    exp_q.push_back(MODE_IDLE);
    req(MODE_IDLE);
    // Core keeps running while the bus is still being asked for
    chk({bus_req, cpu_halt}, 2'h2);
    wait_until(2, 3'h1);
    @(posedge core_clk);
    #1;
    chk({bus_req, cpu_halt}, 2'h3);
  endtask

  // Every state code change must match the oldest note
  always @(posedge core_clk)
    if (rst_n === 1'b1 && state_code !== last_code)
    begin
      last_code <= state_code;
      if (exp_q.size() == 0)
        chk(state_code, 3'h7);
      else
        chk(state_code, exp_q.pop_front());
    end

  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk({state_code, periph_clk_en, periph_pwr_en}, 19'h0FFFF);
    // Frozen clock enable ignores requests
    @(posedge core_clk);
    clk_en <= 1'b0;
    req(MODE_SLOW);
    chk(state_code, MODE_RUN);
    clk_en <= 1'b1;
    exp_q.push_back(MODE_SLOW);
    req(MODE_SLOW);
    chk(core_half_rate, 1'b1);
    exp_q.push_back(MODE_RUN);
    req(MODE_RUN);
    chk({core_half_rate, clk_gate_off, sdram_sr_req}, 3'h0);
    for (int m = 3; m < 5; m++)
    begin
      req(m[2:0]);
      chk(state_code, MODE_RUN);
    end
    repeat (4)
    begin
      seed = xs(seed);
      @(posedge core_clk);
      periph_clk_off <= seed[7:0];
      periph_pwr_off <= seed[15:8];
      @(posedge core_clk);
      #1;
      chk({periph_clk_en, periph_pwr_en}, {~seed[7:0], ~seed[15:8]});
    end
    @(posedge core_clk);
    periph_clk_off <= 8'h00;
    periph_pwr_off <= 8'h00;
    ring_n <= 1'b0;
    wait_until(3, 3'h1);
    chk(state_code, MODE_RUN);
    ring_n <= 1'b1;
    wait_until(3, 3'h0);
    for (int s = 0; s < 2; s++)
    begin
      enter_idle();
      @(posedge core_clk);
      cpu_irq <= (s == 0);
      dma_bus_req <= (s == 1);
      exp_q.push_back(MODE_RUN);
      @(posedge core_clk);
      cpu_irq <= 1'b0;
      dma_bus_req <= 1'b0;
      #1;
      chk({cpu_resume, bus_req, cpu_halt}, 3'h4);
      @(posedge core_clk);
      #1;
      chk(cpu_resume, 1'b0);
    end
    for (int s = 0; s < 4; s++)
    begin
      // Last pass dives from idle straight into deep sleep
      logic [2:0] dive;
      dive = (s == 3) ? MODE_DEEP : MODE_SLEEP;
      enter_idle();
      exp_q.push_back(dive);
      req(dive);
      chk({sdram_sr_req, clk_gate_off}, 2'h2);
      wait_until(1, 3'h1);
      chk({state_code, osc_off, periph_clk_en}, {dive, dive[2], 8'h00});
      if (s != 0)
      begin
        if (s != 3)
        begin
          exp_q.push_back(MODE_DEEP);
          req(MODE_DEEP);
        end
        chk({osc_off, pll_off, power_down, periph_pwr_en, periph_clk_en}, 19'h70000);
        chk({sdram_sr_req, clk_gate_off}, 2'h3);
        exp_q.push_back(MODE_SLEEP);
      end
      exp_q.push_back(MODE_RUN);
      @(posedge core_clk);
      case (s)
        0: user_wake_n <= 1'b0;
        1: rtc_alarm <= 1'b1;
        2: reset_req <= 1'b1;
        default: ring_n <= 1'b0;
      endcase
      wait_until(1, 3'h0);
      chk(sdram_sr_req, 1'b1);
      wait_until(0, MODE_RUN);
      chk({bus_req, cpu_halt, osc_off}, 3'h0);
      @(posedge core_clk);
      user_wake_n <= 1'b1;
      rtc_alarm <= 1'b0;
      reset_req <= 1'b0;
      ring_n <= 1'b1;
    end
    repeat (3) @(posedge core_clk);
    chk(exp_q.size(), 0);
    conclude();
  end
endmodule
